// file: rtl/css_sequencer.sv
/*
  Adaptor detection, soft-start ramp, trickle cycle, current monitor
  select and host watchdog of a battery charger, with an AXI4-Lite slave.
  Assumes comparator inputs arrive asynchronously from the analog front
  end; all other inputs are on mclk_in.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "css_map.svh"

// Overview of operation
// - Ramp charge reference in steps after switches on
// - Charge limit 80 mV, 0.64 mV per code
// - Input limit 80 mV, 1.28 mV per code
// - Option selects monitor source and gain
// - Input limit hit lowers charge reference
// - Low battery: drop to 128 mA, ramp 0.5 A
// - Trickle: 1 ms on, 4 ms off, repeat
// - Battery recovered: leave trickle, keep ramping
// - Energize only with supply above 6.4 V
// - Wake level starts drive supply, flag low
// - Valid after level, headroom and deglitch
// - Valid enables blocks, raises adaptor flag
// - Charge pump ramps switch gate until on
// - Overvoltage drops flag and gate drive
// - Option bit 15 picks deglitch length
// - Option bits 12:11 pick depletion threshold
// - Watchdog expiry stops charging
module css_sequencer #(
  parameter logic [31:0] DGL_SHORT_CYC = `CSS_DGL_SHORT_CYC,
  parameter logic [31:0] DGL_LONG_CYC  = `CSS_DGL_LONG_CYC,
  parameter logic [31:0] TRK_ON_CYC    = `CSS_TRK_ON_CYC,
  parameter logic [31:0] TRK_OFF_CYC   = `CSS_TRK_OFF_CYC,
  parameter logic [31:0] STEP_CYC      = `CSS_STEP_CYC,
  parameter logic [39:0] WDOG_CYC      = 40'(`CSS_WDOG_CYC)
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // Comparator decisions
  input  wire logic        supply_ok_in,
  input  wire logic        wake_in,
  input  wire logic        adp_present_in,
  input  wire logic        headroom_in,
  input  wire logic        adp_ovp_in,
  input  wire logic        gate_full_in,
  input  wire logic        battery_low_level_in,
  input  wire logic        in_limit_hit_in,
  // Analog controls
  output logic             energize_out,
  output logic             gate_drive_supply_out,
  output logic             smbus_ready_out,
  output logic             adaptor_good_flag_out,
  output logic             blocks_en_out,
  output logic             pump_en_out,
  output logic             gate_pulldown_out,
  output logic             charging_out,
  output logic [6:0]       chg_ref_out,
  output logic [5:0]       in_limit_out,
  output logic             mon_sel_out,
  output logic             mon_gain40_out,
  output logic [1:0]       depl_sel_out,
  output logic             irq_out,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************
  // Comparator synchronisers
  // ****************************************
  logic [7:0] cmp_raw;
  logic [7:0] cmp_s1_reg;
  logic [7:0] cmp_s2_reg;
  assign cmp_raw = {in_limit_hit_in, battery_low_level_in, gate_full_in, adp_ovp_in,
                    headroom_in, adp_present_in, wake_in, supply_ok_in};
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_s1_reg <= 8'h00;
      cmp_s2_reg <= 8'h00;
    end else begin
      cmp_s1_reg <= cmp_raw;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end
  logic sup_ok, wake, present, headroom, ovp, gate_full, bat_low, in_hit;
  assign {in_hit, bat_low, gate_full, ovp, headroom, present, wake, sup_ok} = cmp_s2_reg;

  // ****************************************
  // Register bus state
  // ****************************************
  logic [15:0] opt_reg, opt_next;
  logic [6:0]  chg_lim_reg, chg_lim_next;
  logic [5:0]  in_lim_reg, in_lim_next;
  logic [3:0]  imask_reg, imask_next;
  logic [3:0]  istat_reg, istat_next;
  logic        awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
  logic        arr_reg, arr_next, rv_reg, rv_next;
  logic [11:0] wa_reg, wa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  logic        wd_kick;
  logic [3:0]  ev;

  // ****************************************
  // Sequencer state
  // ****************************************
  css_pkg::css_adp_t adp_reg, adp_next;
  css_pkg::css_trk_t trk_reg, trk_next;
  logic [31:0] dgl_reg, dgl_next, trk_cnt_reg, trk_cnt_next, step_reg, step_next;
  logic [39:0] wdc_reg, wdc_next;
  logic        wd_exp_reg, wd_exp_next;
  logic [6:0]  ref_reg, ref_next;
  logic        chg_reg, chg_next;
  logic        chg_en_q_reg;
  logic        chg_ok;
  logic [6:0]  target;

  // Charging allowed only with valid adaptor, switches on, no watchdog
  assign chg_ok = (adp_reg == css_pkg::CSS_VALID) && gate_full && opt_reg[`CSS_OPT_CHG_EN_BIT]
                  && !wd_exp_reg && (chg_lim_reg != 7'h00) && (in_lim_reg != 6'h00);
  // trickle target capped near 0.5 A
  assign target = (trk_reg != css_pkg::CSS_TRK_NONE && chg_lim_reg > `CSS_TRK_MAX_CODE) ?
                  `CSS_TRK_MAX_CODE : chg_lim_reg;

  // Adaptor detection next state
  always_comb begin
    adp_next = adp_reg;
    dgl_next = dgl_reg;
    if (!sup_ok) begin
      adp_next = css_pkg::CSS_OFF;
      dgl_next = 32'h0;
    end else begin
      unique case (adp_reg)
        css_pkg::CSS_OFF: if (wake) adp_next = css_pkg::CSS_WAKE;
        css_pkg::CSS_WAKE: begin
          dgl_next = 32'h0;
          if (!wake) adp_next = css_pkg::CSS_OFF;
          else if (present && headroom) adp_next = css_pkg::CSS_DEGLITCH;
        end
        css_pkg::CSS_DEGLITCH: begin
          dgl_next = dgl_reg + 32'h1;
          if (!(present && headroom)) adp_next = css_pkg::CSS_WAKE;
          else if (dgl_reg + 32'h1 >= (opt_reg[`CSS_OPT_DGL_BIT] ? DGL_LONG_CYC : DGL_SHORT_CYC))
            adp_next = css_pkg::CSS_VALID;
        end
        css_pkg::CSS_VALID: if (!(present && headroom)) adp_next = css_pkg::CSS_WAKE;
        css_pkg::CSS_OVERVOLT: if (!ovp) adp_next = css_pkg::CSS_WAKE;
      endcase
      if (ovp && adp_reg != css_pkg::CSS_OFF) adp_next = css_pkg::CSS_OVERVOLT;
    end
  end

  // Trickle, ramp and watchdog next state
  always_comb begin
    trk_next = trk_reg;
    trk_cnt_next = trk_cnt_reg + 32'h1;
    step_next = step_reg + 32'h1;
    ref_next = ref_reg;
    chg_next = chg_ok;
    wdc_next = wdc_reg + 40'h1;
    wd_exp_next = wd_exp_reg;
    if (wd_kick) begin
      wdc_next = 40'h0;
      wd_exp_next = 1'b0;
    end else if (opt_reg[`CSS_OPT_WD_HI:`CSS_OPT_WD_LO] == 2'b00) begin
      wdc_next = 40'h0;
    end else if (wdc_reg + 40'h1 >= WDOG_CYC) begin
      wdc_next = 40'h0;
      wd_exp_next = 1'b1;
    end
    unique case (trk_reg)
      css_pkg::CSS_TRK_NONE: if (bat_low && chg_ok) begin
        trk_next = css_pkg::CSS_TRK_ON;
        trk_cnt_next = 32'h0;
        ref_next = `CSS_STEP_CODE;
      end
      css_pkg::CSS_TRK_ON: if (!bat_low) trk_next = css_pkg::CSS_TRK_NONE;
        else if (trk_cnt_reg + 32'h1 >= TRK_ON_CYC) begin
          trk_next = css_pkg::CSS_TRK_OFF;
          trk_cnt_next = 32'h0;
        end
      css_pkg::CSS_TRK_OFF: if (!bat_low) trk_next = css_pkg::CSS_TRK_NONE;
        else if (trk_cnt_reg + 32'h1 >= TRK_OFF_CYC) begin
          trk_next = css_pkg::CSS_TRK_ON;
          trk_cnt_next = 32'h0;
          ref_next = `CSS_STEP_CODE;
        end
    endcase
    if (trk_reg == css_pkg::CSS_TRK_OFF) chg_next = 1'b0;
    // restart ramp on each charge enable
    if (!chg_ok) begin
      ref_next = 7'h00;
      step_next = 32'h0;
      trk_next = css_pkg::CSS_TRK_NONE;
    end else if (!chg_en_q_reg) begin
      ref_next = 7'h00;
      step_next = 32'h0;
    end else if (in_hit) begin
      if (step_reg + 32'h1 >= STEP_CYC) begin
        step_next = 32'h0;
        ref_next = (ref_reg > `CSS_STEP_CODE) ? ref_reg - `CSS_STEP_CODE : 7'h00;
      end
    end else if (step_reg + 32'h1 >= STEP_CYC) begin
      step_next = 32'h0;
      if (ref_reg > target) ref_next = target;
      else if (target - ref_reg > `CSS_STEP_CODE) ref_next = ref_reg + `CSS_STEP_CODE;
      else ref_next = target;
    end
    if (chg_ok && chg_en_q_reg && trk_next == css_pkg::CSS_TRK_ON && trk_reg != css_pkg::CSS_TRK_ON)
      ref_next = `CSS_STEP_CODE;
  end

  // Sequencer registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adp_reg <= css_pkg::CSS_OFF;
      trk_reg <= css_pkg::CSS_TRK_NONE;
      dgl_reg <= 32'h0;
      trk_cnt_reg <= 32'h0;
      step_reg <= 32'h0;
      wdc_reg <= 40'h0;
      wd_exp_reg <= 1'b0;
      ref_reg <= 7'h00;
      chg_reg <= 1'b0;
      chg_en_q_reg <= 1'b0;
    end else begin
      adp_reg <= adp_next;
      trk_reg <= trk_next;
      dgl_reg <= dgl_next;
      trk_cnt_reg <= trk_cnt_next;
      step_reg <= step_next;
      wdc_reg <= wdc_next;
      wd_exp_reg <= wd_exp_next;
      ref_reg <= ref_next;
      chg_reg <= chg_next;
      chg_en_q_reg <= chg_ok;
    end
  end

  // Interrupt events
  assign ev[`CSS_IRQ_VALID] = (adp_next == css_pkg::CSS_VALID) && (adp_reg != css_pkg::CSS_VALID);
  assign ev[`CSS_IRQ_OVP] = (adp_next == css_pkg::CSS_OVERVOLT) && (adp_reg != css_pkg::CSS_OVERVOLT);
  assign ev[`CSS_IRQ_TRICKLE] = (trk_reg == css_pkg::CSS_TRK_NONE) && (trk_next == css_pkg::CSS_TRK_ON);
  assign ev[`CSS_IRQ_WDOG] = wd_exp_next && !wd_exp_reg;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic do_wr;
  assign do_wr = awr_reg && wr_reg && !bv_reg;
  assign wd_kick = do_wr || (s_axi_arvalid && arr_reg);

  // Bus next state
  always_comb begin
    awr_next = awr_reg;
    wr_next = wr_reg;
    wa_next = wa_reg;
    wd_next = wd_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    arr_next = 1'b0;
    rv_next = rv_reg;
    rr_next = rr_reg;
    rd_next = rd_reg;
    opt_next = opt_reg;
    chg_lim_next = chg_lim_reg;
    in_lim_next = in_lim_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    if (s_axi_awvalid && !awr_reg && !bv_reg) begin
      awr_next = 1'b1;
      wa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wr_reg && !bv_reg) begin
      wr_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (do_wr) begin
      awr_next = 1'b0;
      wr_next = 1'b0;
      bv_next = 1'b1;
      br_next = 2'b00;
      unique case (wa_reg)
        `CSS_OFS_OPTION: begin
          if (s_axi_wstrb[0]) opt_next[7:0] = wd_reg[7:0];
          if (s_axi_wstrb[1]) opt_next[15:8] = wd_reg[15:8];
        end
        // charge limit code, 0.64 mV each
        `CSS_OFS_CHG_LIMIT: chg_lim_next = (wd_reg[6:0] > `CSS_CHG_FS_CODE) ? `CSS_CHG_FS_CODE : wd_reg[6:0];
        // input limit code, 1.28 mV each
        `CSS_OFS_IN_LIMIT: in_lim_next = (wd_reg[5:0] > `CSS_IN_FS_CODE) ? `CSS_IN_FS_CODE : wd_reg[5:0];
        `CSS_OFS_IRQ_STAT: istat_next = istat_reg & ~wd_reg[3:0];
        `CSS_OFS_IRQ_MASK: imask_next = wd_reg[3:0];
        `CSS_OFS_STATUS, `CSS_OFS_WD_KICK: ;
        default: br_next = 2'b10;
      endcase
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    // Set wins over a same-cycle clear
    istat_next = istat_next | ev;
    if (s_axi_arvalid && !arr_reg && !rv_reg) arr_next = 1'b1;
    if (s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rr_next = 2'b00;
      unique case (s_axi_araddr)
        `CSS_OFS_OPTION: rd_next = {16'h0, opt_reg};
        `CSS_OFS_CHG_LIMIT: rd_next = {25'h0, chg_lim_reg};
        `CSS_OFS_IN_LIMIT: rd_next = {26'h0, in_lim_reg};
        `CSS_OFS_STATUS: rd_next = {17'h0, ref_reg, 1'b0, trk_reg, wd_exp_reg, chg_reg, adp_reg};
        `CSS_OFS_IRQ_STAT: rd_next = {28'h0, istat_reg};
        `CSS_OFS_IRQ_MASK: rd_next = {28'h0, imask_reg};
        `CSS_OFS_WD_KICK: rd_next = 32'h0;
        default: begin
          rd_next = 32'h0;
          rr_next = 2'b10;
        end
      endcase
    end
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
  end

  // Bus registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awr_reg <= 1'b0;
      wr_reg <= 1'b0;
      bv_reg <= 1'b0;
      arr_reg <= 1'b0;
      rv_reg <= 1'b0;
      wa_reg <= 12'h000;
      wd_reg <= 32'h0;
      rd_reg <= 32'h0;
      br_reg <= 2'b00;
      rr_reg <= 2'b00;
      opt_reg <= `CSS_OPT_RESET;
      chg_lim_reg <= 7'h00;
      in_lim_reg <= 6'h00;
      imask_reg <= 4'h0;
      istat_reg <= 4'h0;
    end else begin
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      bv_reg <= bv_next;
      arr_reg <= arr_next;
      rv_reg <= rv_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      br_reg <= br_next;
      rr_reg <= rr_next;
      opt_reg <= opt_next;
      chg_lim_reg <= chg_lim_next;
      in_lim_reg <= in_lim_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      energize_out <= 1'b0;
      gate_drive_supply_out <= 1'b0;
      smbus_ready_out <= 1'b0;
      adaptor_good_flag_out <= 1'b0;
      blocks_en_out <= 1'b0;
      pump_en_out <= 1'b0;
      gate_pulldown_out <= 1'b1;
      charging_out <= 1'b0;
      chg_ref_out <= 7'h00;
      in_limit_out <= 6'h00;
      mon_sel_out <= 1'b0;
      mon_gain40_out <= 1'b0;
      depl_sel_out <= 2'b00;
      irq_out <= 1'b0;
    end else begin
      energize_out <= sup_ok;
      gate_drive_supply_out <= (adp_next != css_pkg::CSS_OFF);
      smbus_ready_out <= (adp_next != css_pkg::CSS_OFF);
      adaptor_good_flag_out <= (adp_next == css_pkg::CSS_VALID);
      blocks_en_out <= (adp_next == css_pkg::CSS_VALID);
      pump_en_out <= (adp_next == css_pkg::CSS_VALID) && !gate_full;
      gate_pulldown_out <= (adp_next != css_pkg::CSS_VALID);
      charging_out <= chg_next;
      chg_ref_out <= ref_next;
      in_limit_out <= in_lim_next;
      mon_sel_out <= opt_next[`CSS_OPT_MON_SEL_BIT];
      mon_gain40_out <= opt_next[`CSS_OPT_GAIN_BIT];
      depl_sel_out <= opt_next[`CSS_OPT_DEP_HI:`CSS_OPT_DEP_LO];
      irq_out <= |(istat_next & imask_next);
    end
  end

  assign s_axi_awready = awr_reg && wr_reg && !bv_reg;
  assign s_axi_wready = awr_reg && wr_reg && !bv_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_ovp_seen;
    ovp && adp_reg != css_pkg::CSS_OFF && sup_ok;
  endsequence
  chk_ovp_flag_low: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    s_ovp_seen |=> ##1 !adaptor_good_flag_out && gate_pulldown_out) else $error("flag high in overvoltage");
  chk_supply_gates_all: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !sup_ok |=> adp_reg == css_pkg::CSS_OFF) else $error("active without supply");
  chk_wake_flag_low: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    adp_reg == css_pkg::CSS_WAKE |-> ##1 !adaptor_good_flag_out) else $error("flag high at wake");
  chk_valid_needs_dgl: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $rose(adp_reg == css_pkg::CSS_VALID) |-> $past(dgl_reg) + 32'h1 >= DGL_SHORT_CYC) else $error("early valid");
  chk_valid_flag_high: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    adp_reg == css_pkg::CSS_VALID |-> adaptor_good_flag_out && blocks_en_out) else $error("flag not raised");
  chk_pump_until_on: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    pump_en_out |-> adp_reg == css_pkg::CSS_VALID) else $error("pump outside valid");
  chk_ramp_step_size: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ref_reg > $past(ref_reg) && $past(ref_reg) != 7'h00 |-> ref_reg - $past(ref_reg) <= `CSS_STEP_CODE)
    else $error("ramp step too large");
  chk_trickle_cap: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    trk_reg != css_pkg::CSS_TRK_NONE && $past(trk_reg) != css_pkg::CSS_TRK_NONE |-> ref_reg <= `CSS_TRK_MAX_CODE)
    else $error("trickle over cap");
  chk_trickle_pause: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    trk_reg == css_pkg::CSS_TRK_OFF |=> !charging_out) else $error("charging in pause");
  chk_wdog_stops: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wd_exp_reg |-> ##1 !charging_out) else $error("charging after watchdog");

endmodule

// file: rtl/css_map.svh
/*
  Timing counts, option word bit positions and register map of the
  charger adaptor soft-start sequencer.
  Assumes a 250 MHz core clock (4 ns period).
*/
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH

// ****************************************
// Clock and times
// ****************************************
`define CSS_CLK_PERIOD_NS    4
`define CSS_STEP_TIME_US     240
`define CSS_STEP_CYC         ((`CSS_STEP_TIME_US * 1000) / `CSS_CLK_PERIOD_NS)
`define CSS_DGL_SHORT_MS     175
`define CSS_DGL_SHORT_CYC    ((`CSS_DGL_SHORT_MS * 1000000) / `CSS_CLK_PERIOD_NS)
`define CSS_DGL_LONG_MS      1400
`define CSS_DGL_LONG_CYC     ((`CSS_DGL_LONG_MS * 1000000) / `CSS_CLK_PERIOD_NS)
`define CSS_TRK_ON_MS        1
`define CSS_TRK_ON_CYC       ((`CSS_TRK_ON_MS * 1000000) / `CSS_CLK_PERIOD_NS)
`define CSS_TRK_OFF_MS       4
`define CSS_TRK_OFF_CYC      ((`CSS_TRK_OFF_MS * 1000000) / `CSS_CLK_PERIOD_NS)
`define CSS_WDOG_S           170
`define CSS_WDOG_CYC         (64'd170 * 64'd250000000)

// ****************************************
// Current codes (charge code LSB is 0.64 mV = 64 mA at 10 mOhm)
// ****************************************
`define CSS_STEP_CODE        7'h02
`define CSS_TRK_MAX_CODE     7'h08
`define CSS_CHG_FS_CODE      7'h7d
`define CSS_IN_FS_CODE       6'h3e

// ****************************************
// Option word fields
// ****************************************
`define CSS_OPT_DGL_BIT      15
`define CSS_OPT_WD_HI        14
`define CSS_OPT_WD_LO        13
`define CSS_OPT_DEP_HI       12
`define CSS_OPT_DEP_LO       11
`define CSS_OPT_MON_SEL_BIT  5
`define CSS_OPT_GAIN_BIT     4
`define CSS_OPT_CHG_EN_BIT   0
`define CSS_OPT_RESET        16'h0000

// ****************************************
// Register byte offsets
// ****************************************
`define CSS_OFS_OPTION       12'h000
`define CSS_OFS_CHG_LIMIT    12'h004
`define CSS_OFS_IN_LIMIT     12'h008
`define CSS_OFS_STATUS       12'h00c
`define CSS_OFS_IRQ_STAT     12'h010
`define CSS_OFS_IRQ_MASK     12'h014
`define CSS_OFS_WD_KICK      12'h018

// Interrupt status bits
`define CSS_IRQ_VALID        0
`define CSS_IRQ_OVP          1
`define CSS_IRQ_TRICKLE      2
`define CSS_IRQ_WDOG         3
`define CSS_IRQ_W            4

`endif

// file: rtl/css_pkg.sv
/*
  Types of the charger adaptor soft-start sequencer.
  Assumes the map header for all numeric constants.
*/
package css_pkg;
  typedef enum logic [2:0] {
    CSS_OFF,
    CSS_WAKE,
    CSS_DEGLITCH,
    CSS_VALID,
    CSS_OVERVOLT
  } css_adp_t;
  typedef enum logic [1:0] {
    CSS_TRK_NONE,
    CSS_TRK_ON,
    CSS_TRK_OFF
  } css_trk_t;
endpackage

// file: tb/css_gate_model.sv
/*
  Far-side model of the adaptor switch gate: the charge pump ramps the gate
  and the switch-on comparator reports when the switches are fully on.
  Assumes pump and pulldown controls change on mclk_in.
*/
`timescale 1ns/1ps
// ****************************************
// Gate ramp model
// ****************************************
module css_gate_model #(
  parameter int RAMP = 16
) (
  // Controls from the sequencer
  input  wire logic mclk_in,
  input  wire logic pump_en_in,
  input  wire logic gate_pulldown_in,
  // Comparator back to the sequencer
  output logic      gate_full_out
);
  int cnt = 0;
  // gate rises while pumped, drops on pulldown
  always @(posedge mclk_in) begin
    if (gate_pulldown_in) cnt <= 0;
    else if (pump_en_in && cnt < RAMP) cnt <= cnt + 1;
  end
  // Full only once the ramp is complete
  assign gate_full_out = !gate_pulldown_in && cnt >= RAMP;
endmodule

// file: tb/tb_top.sv
/*
  Self-checking bench of the charger sequencer: register rows, then
  adaptor detection, trickle, interrupt and overvoltage cases.
  Assumes the gate model answers gate-full after its ramp.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] r;} css_row_t;
  logic mclk_in, nrst_in, supply_ok_in, wake_in, adp_present_in, headroom_in, adp_ovp_in, gate_full_in;
  logic battery_low_level_in, in_limit_hit_in, energize_out, gate_drive_supply_out, smbus_ready_out;
  logic adaptor_good_flag_out, blocks_en_out, pump_en_out, gate_pulldown_out, charging_out, mon_sel_out;
  logic mon_gain40_out, irq_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0] chg_ref_out;
  logic [5:0] in_limit_out;
  logic [1:0] depl_sel_out, s_axi_bresp, s_axi_rresp, rs;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  int err_total = 0, n_tests = 0, i;
  css_row_t rows[8] = '{'{12'h000, 32'h0000, 2'b00}, '{12'h000, 32'h0810, 2'b00}, '{12'h000, 32'h1020, 2'b00},
    '{12'h000, 32'h1830, 2'b00}, '{12'h004, 32'h7d, 2'b00}, '{12'h008, 32'h3e, 2'b00},
    '{12'h014, 32'h4, 2'b00}, '{12'h040, 32'h5, 2'b10}};

  css_sequencer #(.DGL_SHORT_CYC(32'd50), .DGL_LONG_CYC(32'd200), .TRK_ON_CYC(32'd40), .TRK_OFF_CYC(32'd120),
    .STEP_CYC(32'd400),
    .WDOG_CYC(40'd5000)) uut (.mclk_in, .nrst_in, .supply_ok_in, .wake_in, .adp_present_in, .headroom_in,
    .adp_ovp_in, .gate_full_in, .battery_low_level_in, .in_limit_hit_in, .energize_out, .gate_drive_supply_out,
    .smbus_ready_out, .adaptor_good_flag_out, .blocks_en_out, .pump_en_out, .gate_pulldown_out, .charging_out,
    .chg_ref_out, .in_limit_out, .mon_sel_out, .mon_gain40_out, .depl_sel_out, .irq_out, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  css_gate_model #(.RAMP(16)) gm (.mclk_in, .pump_en_in(pump_en_out), .gate_pulldown_in(gate_pulldown_out),
    .gate_full_out(gate_full_in));

  // Clock and hang guard
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    final_report();
  end

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Bus write, address and data offered together
  task axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge mclk_in); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge mclk_in); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task axr(input logic [11:0] a);
    @(posedge mclk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk_in); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Counts and verdict
  task final_report;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial begin
    {nrst_in, supply_ok_in, wake_in, adp_present_in, headroom_in, adp_ovp_in} = '0;
    {battery_low_level_in, in_limit_hit_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge mclk_in);
    chk({adaptor_good_flag_out, gate_pulldown_out}, 2'b01);
    nrst_in <= 1'b1;
    supply_ok_in <= 1'b1;
    wake_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    chk(energize_out, 1'b1);
    chk({gate_drive_supply_out, smbus_ready_out, adaptor_good_flag_out}, 3'b110);
    $display("test power-up done");
    foreach (rows[k]) begin
      axw(rows[k].a, rows[k].d);
      chk(rs, rows[k].r);
      axr(rows[k].a);
      chk(rs, rows[k].r);
      if (rs === 2'b00) chk(rd, rows[k].d);
      repeat (2) @(posedge mclk_in);
      if (rows[k].a == 12'h000) chk({depl_sel_out, mon_sel_out, mon_gain40_out}, {rows[k].d[12:11], rows[k].d[5:4]});
    end
    $display("test registers done");
    chk(in_limit_out, 6'h3e);
    adp_present_in <= 1'b1;
    headroom_in <= 1'b1;
    for (i = 0; i < 100 && adaptor_good_flag_out !== 1'b1; i++) @(posedge mclk_in);
    chk(i >= 50 && i <= 58, 1);
    chk(blocks_en_out, 1'b1);
    repeat (30) @(posedge mclk_in);
    chk({pump_en_out, gate_pulldown_out, irq_out}, 3'b000);
    axw(12'h000, 32'h1831);
    for (i = 0; i < 20 && charging_out !== 1'b1; i++) @(posedge mclk_in);
    chk({charging_out, chg_ref_out}, 8'h80);
    $display("test adaptor done");
    battery_low_level_in <= 1'b1;
    for (i = 0; i < 10 && chg_ref_out !== 7'h02; i++) @(posedge mclk_in);
    chk(chg_ref_out, 7'h02);
    for (i = 0; i < 60 && charging_out !== 1'b0; i++) @(posedge mclk_in);
    chk(i >= 32 && i <= 48, 1);
    for (i = 0; i < 200 && charging_out !== 1'b1; i++) @(posedge mclk_in);
    chk(i >= 118 && i <= 124, 1);
    chk(irq_out, 1'b1);
    axw(12'h010, 32'h4);
    repeat (3) @(posedge mclk_in);
    chk(irq_out, 1'b0);
    battery_low_level_in <= 1'b0;
    repeat (100) @(posedge mclk_in);
    chk(charging_out, 1'b1);
    $display("test trickle done");
    for (i = 0; i < 500 && chg_ref_out === 7'h02; i++) @(posedge mclk_in);
    chk(chg_ref_out, 7'h04);
    in_limit_hit_in <= 1'b1;
    for (i = 0; i < 500 && chg_ref_out === 7'h04; i++) @(posedge mclk_in);
    chk(i, 400);
    chk(chg_ref_out, 7'h02);
    in_limit_hit_in <= 1'b0;
    $display("test ramp done");
    s_axi_wstrb <= 4'h2;
    axw(12'h000, 32'h2000);
    s_axi_wstrb <= 4'hf;
    chk({depl_sel_out, mon_sel_out, mon_gain40_out}, 4'b0011);
    for (i = 0; i < 6000 && charging_out === 1'b1; i++) @(posedge mclk_in);
    chk(i >= 4995 && i <= 5005, 1);
    axr(12'h00c);
    chk(rd[4:3], 2'b10);
    $display("test watchdog done");
    adp_ovp_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    chk({adaptor_good_flag_out, gate_pulldown_out, charging_out}, 3'b010);
    $display("test overvoltage done");
    supply_ok_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    chk({energize_out, gate_drive_supply_out, smbus_ready_out}, 3'b000);
    $display("test supply loss done");
    final_report();
  end
endmodule
